//--- hw/bce_cfg.svh
`ifndef BCE_CFG_SVH
`define BCE_CFG_SVH

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define BCE_TMR_W 16
`define BCE_TMO_CYC 16'h0040
`define BCE_SYNC_CYC 4'h2

// ----------------------------------------------------------------
// pin sampling
// ----------------------------------------------------------------
`define BCE_PIN_W 6
`define BCE_PIN_IDLE 6'h3F
`define BCE_PIN_ACK0 0
`define BCE_PIN_ACK1 1
`define BCE_PIN_FAULT 2
`define BCE_PIN_STOP 3
`define BCE_PIN_AUTO_VECTOR_INPUT 4
`define BCE_PIN_BREQ 5

`endif

//--- hw/bce_pkg.sv
package bce_pkg;

    typedef enum logic [3:0] {
        BCE_ST_IDLE = 4'b0000,
        BCE_ST_DRIVE = 4'b0001,
        BCE_ST_WAIT = 4'b0010,
        BCE_ST_LATE = 4'b0011,
        BCE_ST_END = 4'b0100,
        BCE_ST_RETRY = 4'b0101,
        BCE_ST_RELEASE = 4'b0110,
        BCE_ST_SYNC = 4'b0111
    } bce_state_t;

    typedef enum logic [1:0] {
        BCE_TK_NORM = 2'b00,
        BCE_TK_HALT = 2'b01,
        BCE_TK_ERR = 2'b10,
        BCE_TK_RETRY = 2'b11
    } bce_term_t;

endpackage

//--- hw/bce_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bce_sync
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [W-1:0] i_d,
    output var logic [W-1:0] o_q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    // ------------------------------------------------------------
    // accept a change once stages two and three agree
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_q <= RST_VAL;
        end
        else
        begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q <= q_d;
        end
    end

    assign o_q = q_q;

endmodule // bce_sync

`default_nettype wire

//--- hw/bce_ctrl.sv
// Overview of operation
// - no acknowledge within the timeout after strobe: device ends cycle with fault
// - sample inputs at N and N+1; acknowledge alone ends normally
// - stop no later than acknowledge, no fault: finish, then halt until released
// - fault without stop, any time around acknowledge: bus error exception, unless locked with request
// - fault together with stop around acknowledge: retry the cycle
// - error on fault alone, or fault one clock after acknowledge
// - fault wins over acknowledge; data of that cycle is invalid
// - error cycle ends normally; exception raised now or deferred
// - prefetch error held until word used; dropped on branch or switch
// - retry: controls inactive, no new cycle until fault and stop negate
// - after a sync delay reissue same address, code, size, direction
// - locked sequence retries each cycle alone, lock output held throughout
// - request with fault and stop releases bus outside locked sequence; locked, request with fault alone releases
// - release during byte-port word, outside cycle intervenes: redo whole word
// - stop alone steps bus one cycle per negation
// - after a stopped cycle: float data, controls inactive, address held
`timescale 1ns/1ps
`default_nettype none
`include "bce_cfg.svh"

module bce_ctrl
    import bce_pkg::*;
#(
    parameter logic [`BCE_TMR_W-1:0] TMO_CYC = `BCE_TMO_CYC,
    parameter logic [3:0] SYNC_CYC = `BCE_SYNC_CYC
)
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_req,
    input wire logic [31:0] i_req_addr,
    input wire logic [3:0] i_req_fc,
    input wire logic [1:0] i_req_size,
    input wire logic i_req_read,
    input wire logic i_req_locked,
    input wire logic i_req_iack,
    input wire logic i_req_prefetch,
    input wire logic i_req_byte_word,
    input wire logic i_rmw_seq,
    input wire logic i_prefetch_used,
    input wire logic i_prefetch_flush,
    input wire logic i_ext_to_int,
    input wire logic [1:0] i_data_size_ack_n,
    input wire logic i_bus_fault_in_n,
    input wire logic i_stop_n,
    input wire logic i_auto_vector_input_n,
    input wire logic i_mastership_request_n,
    output var logic [31:0] o_addr,
    output var logic [3:0] o_fc,
    output var logic [1:0] o_size,
    output var logic o_read,
    output var logic o_addr_strobe_n,
    output var logic o_data_oe_n,
    output var logic o_ctrl_oe_n,
    output var logic o_locked_rmw_n,
    output var logic o_busy,
    output var logic o_done,
    output var logic o_data_valid,
    output var logic o_bus_error,
    output var logic o_err_pending,
    output var logic o_retry,
    output var logic o_halted,
    output var logic o_bus_released,
    output var logic o_word_restart
);

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    logic [`BCE_PIN_W-1:0] pin_n;

    bce_sync #(
        .W(`BCE_PIN_W),
        .RST_VAL(`BCE_PIN_IDLE)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_d({i_mastership_request_n, i_auto_vector_input_n, i_stop_n,
              i_bus_fault_in_n, i_data_size_ack_n}),
        .o_q(pin_n)
    );

    logic ack;
    logic flt_pin;
    logic flt;
    logic stp;
    logic breq;
    logic tmo_hit;

    bce_state_t st_q, st_d;
    bce_term_t kind_q, kind_d;
    logic [`BCE_TMR_W-1:0] tmr_q, tmr_d;
    logic [3:0] sync_q, sync_d;
    logic [31:0] addr_q, addr_d;
    logic [3:0] fc_q, fc_d;
    logic [1:0] size_q, size_d;
    logic read_q, read_d;
    logic lck_q, lck_d;
    logic iack_q, iack_d;
    logic pf_q, pf_d;
    logic bw_q, bw_d;
    logic redo_q, redo_d;
    logic pend_q, pend_d;
    logic as_n_q, as_n_d;
    logic doe_n_q, doe_n_d;
    logic coe_n_q, coe_n_d;
    logic lk_n_q, lk_n_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic dval_q, dval_d;
    logic bus_fault_in_q, bus_fault_in_d;
    logic retry_q, retry_d;
    logic halt_q, halt_d;
    logic rel_q, rel_d;
    logic wrst_q, wrst_d;

    // ------------------------------------------------------------
    // decoded inputs
    // ------------------------------------------------------------
    always_comb
    begin
        ack = !pin_n[`BCE_PIN_ACK0] || !pin_n[`BCE_PIN_ACK1]
            || (iack_q && !pin_n[`BCE_PIN_AUTO_VECTOR_INPUT]);
        flt_pin = !pin_n[`BCE_PIN_FAULT];
        tmo_hit = (tmr_q >= TMO_CYC);
        flt = flt_pin || tmo_hit;
        stp = !pin_n[`BCE_PIN_STOP];
        breq = !pin_n[`BCE_PIN_BREQ];
    end

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        kind_d = kind_q;
        tmr_d = tmr_q;
        sync_d = sync_q;
        addr_d = addr_q;
        fc_d = fc_q;
        size_d = size_q;
        read_d = read_q;
        lck_d = lck_q;
        iack_d = iack_q;
        pf_d = pf_q;
        bw_d = bw_q;
        redo_d = redo_q;
        as_n_d = as_n_q;
        doe_n_d = doe_n_q;
        coe_n_d = coe_n_q;
        done_d = 1'b0;
        dval_d = 1'b0;
        retry_d = 1'b0;
        wrst_d = 1'b0;
        rel_d = 1'b0;
        bus_fault_in_d = pend_q && i_prefetch_used;
        pend_d = pend_q && !i_prefetch_used && !i_prefetch_flush;
        case (st_q)
            BCE_ST_IDLE:
            begin
                if (i_req && !stp)
                begin
                    addr_d = i_req_addr;
                    fc_d = i_req_fc;
                    size_d = i_req_size;
                    read_d = i_req_read;
                    lck_d = i_req_locked;
                    iack_d = i_req_iack;
                    pf_d = i_req_prefetch;
                    bw_d = i_req_byte_word;
                    st_d = BCE_ST_DRIVE;
                end
            end
            BCE_ST_DRIVE:
            begin
                as_n_d = 1'b0;
                coe_n_d = 1'b0;
                doe_n_d = read_q;
                tmr_d = '0;
                st_d = BCE_ST_WAIT;
            end
            BCE_ST_WAIT:
            begin
                tmr_d = tmr_q + 1'b1;
                if (flt)
                begin
                    kind_d = (stp || (lck_q && breq)) ? BCE_TK_RETRY
                        : BCE_TK_ERR;
                    st_d = BCE_ST_END;
                end
                else if (ack)
                begin
                    kind_d = stp ? BCE_TK_HALT : BCE_TK_NORM;
                    st_d = stp ? BCE_ST_END : BCE_ST_LATE;
                end
            end
            BCE_ST_LATE:
            begin
                if (flt_pin)
                begin
                    kind_d = (stp || (lck_q && breq)) ? BCE_TK_RETRY
                        : BCE_TK_ERR;
                end
                else
                begin
                    kind_d = BCE_TK_NORM;
                end
                st_d = BCE_ST_END;
            end
            BCE_ST_END:
            begin
                as_n_d = 1'b1;
                doe_n_d = 1'b1;
                case (kind_q)
                    BCE_TK_ERR:
                    begin
                        done_d = 1'b1;
                        if (pf_q)
                        begin
                            pend_d = 1'b1;
                        end
                        else
                        begin
                            bus_fault_in_d = 1'b1;
                        end
                        st_d = BCE_ST_IDLE;
                    end
                    BCE_TK_RETRY:
                    begin
                        retry_d = 1'b1;
                        if (breq && (lck_q ? !stp : 1'b1))
                        begin
                            coe_n_d = 1'b1;
                            redo_d = 1'b0;
                            st_d = BCE_ST_RELEASE;
                        end
                        else
                        begin
                            st_d = BCE_ST_RETRY;
                        end
                    end
                    default:
                    begin
                        done_d = 1'b1;
                        dval_d = read_q;
                        st_d = BCE_ST_IDLE;
                    end
                endcase
            end
            BCE_ST_RETRY:
            begin
                if (!flt_pin && !stp)
                begin
                    sync_d = '0;
                    st_d = BCE_ST_SYNC;
                end
            end
            BCE_ST_RELEASE:
            begin
                rel_d = 1'b1;
                if (bw_q && i_ext_to_int)
                begin
                    redo_d = 1'b1;
                end
                if (!breq && !flt_pin && !stp)
                begin
                    rel_d = 1'b0;
                    coe_n_d = 1'b0;
                    sync_d = '0;
                    if (redo_q)
                    begin
                        wrst_d = 1'b1;
                        done_d = 1'b1;
                        st_d = BCE_ST_IDLE;
                    end
                    else
                    begin
                        st_d = BCE_ST_SYNC;
                    end
                end
            end
            BCE_ST_SYNC:
            begin
                sync_d = sync_q + 1'b1;
                if (sync_q + 1'b1 >= SYNC_CYC)
                begin
                    st_d = BCE_ST_DRIVE;
                end
            end
            default:
            begin
                st_d = BCE_ST_IDLE;
            end
        endcase
        busy_d = (st_d != BCE_ST_IDLE);
        halt_d = (st_d == BCE_ST_IDLE) && stp;
        lk_n_d = !((busy_d && lck_d) || i_rmw_seq);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            st_q <= BCE_ST_IDLE;
            kind_q <= BCE_TK_NORM;
            tmr_q <= '0;
            sync_q <= 4'h0;
            addr_q <= 32'h0000_0000;
            fc_q <= 4'h0;
            size_q <= 2'h0;
            read_q <= 1'b1;
            lck_q <= 1'b0;
            iack_q <= 1'b0;
            pf_q <= 1'b0;
            bw_q <= 1'b0;
            redo_q <= 1'b0;
            pend_q <= 1'b0;
            as_n_q <= 1'b1;
            doe_n_q <= 1'b1;
            coe_n_q <= 1'b0;
            lk_n_q <= 1'b1;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            dval_q <= 1'b0;
            bus_fault_in_q <= 1'b0;
            retry_q <= 1'b0;
            halt_q <= 1'b0;
            rel_q <= 1'b0;
            wrst_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            kind_q <= kind_d;
            tmr_q <= tmr_d;
            sync_q <= sync_d;
            addr_q <= addr_d;
            fc_q <= fc_d;
            size_q <= size_d;
            read_q <= read_d;
            lck_q <= lck_d;
            iack_q <= iack_d;
            pf_q <= pf_d;
            bw_q <= bw_d;
            redo_q <= redo_d;
            pend_q <= pend_d;
            as_n_q <= as_n_d;
            doe_n_q <= doe_n_d;
            coe_n_q <= coe_n_d;
            lk_n_q <= lk_n_d;
            busy_q <= busy_d;
            done_q <= done_d;
            dval_q <= dval_d;
            bus_fault_in_q <= bus_fault_in_d;
            retry_q <= retry_d;
            halt_q <= halt_d;
            rel_q <= rel_d;
            wrst_q <= wrst_d;
        end
    end

    assign o_addr = addr_q;
    assign o_fc = fc_q;
    assign o_size = size_q;
    assign o_read = read_q;
    assign o_addr_strobe_n = as_n_q;
    assign o_data_oe_n = doe_n_q;
    assign o_ctrl_oe_n = coe_n_q;
    assign o_locked_rmw_n = lk_n_q;
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_data_valid = dval_q;
    assign o_bus_error = bus_fault_in_q;
    assign o_err_pending = pend_q;
    assign o_retry = retry_q;
    assign o_halted = halt_q;
    assign o_bus_released = rel_q;
    assign o_word_restart = wrst_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    timeout_term_a: assert property (
        (st_q == BCE_ST_WAIT && tmr_q >= TMO_CYC) |=> st_q == BCE_ST_END
        ##1 o_addr_strobe_n) else $error("timeout did not end cycle");
    normal_end_a: assert property (
        (st_q == BCE_ST_LATE && !flt_pin) |=> kind_q == BCE_TK_NORM
        ##1 (o_done && !o_bus_error)) else $error("normal end missed");
    halt_hold_a: assert property (
        (st_q == BCE_ST_IDLE && stp) |=> st_q == BCE_ST_IDLE)
        else $error("cycle started while stopped");
    fault_err_a: assert property (
        (st_q == BCE_ST_WAIT && flt && !stp && !breq && !pf_q)
        |=> ##1 o_bus_error) else $error("bus error not raised");
    retry_kind_a: assert property (
        (st_q == BCE_ST_WAIT && flt && stp) |=> kind_q == BCE_TK_RETRY
        ##1 o_retry) else $error("retry not taken");
    bad_data_a: assert property (
        (st_q == BCE_ST_END && kind_q == BCE_TK_ERR) |=> !o_data_valid)
        else $error("faulted data flagged valid");
    retry_wait_a: assert property (
        (st_q == BCE_ST_RETRY && (flt_pin || stp)) |=>
        (st_q == BCE_ST_RETRY && o_addr_strobe_n))
        else $error("new cycle during retry hold");
    reissue_same_a: assert property (
        (st_q == BCE_ST_SYNC) |=> $stable(o_addr) && $stable(o_fc)
        && $stable(o_size) && $stable(o_read))
        else $error("retried access changed");
    lock_held_a: assert property (
        (busy_q && lck_q) |-> !o_locked_rmw_n)
        else $error("lock dropped during sequence");
    no_release_a: assert property (
        (st_q == BCE_ST_END && kind_q == BCE_TK_RETRY && lck_q && stp)
        |=> st_q != BCE_ST_RELEASE) else $error("bus released when locked");
    float_end_a: assert property (
        (st_q == BCE_ST_END) |=> (o_data_oe_n && o_addr_strobe_n))
        else $error("bus not floated after cycle");

    cover_retry_c: cover property (o_retry ##[1:40] o_addr_strobe_n == 1'b0);
    cover_late_c: cover property (st_q == BCE_ST_LATE && flt_pin);
    cover_release_c: cover property (o_bus_released ##[1:40] o_word_restart);
    cover_halt_c: cover property (o_done ##1 o_halted);

endmodule // bce_ctrl

`default_nettype wire

//--- sim/bce_resp.sv
`timescale 1ns/1ps
`default_nettype none

module bce_resp
(
    input wire logic i_ref_clk,
    input wire logic i_addr_strobe_n,
    input wire logic [3:0] i_mode,
    input wire logic [1:0] i_dly,
    output var logic [1:0] o_ack_n,
    output var logic o_fault_n,
    output var logic o_stop_n,
    output var logic o_auto_vector_input_n,
    output var logic o_breq_n
);
    logic [3:0] m;

    // ------------------------------------------------------------
    // responder, switches pins on rising edges only
    // ------------------------------------------------------------
    initial
    begin
        o_ack_n = 2'b11;
        o_fault_n = 1'b1;
        o_stop_n = 1'b1;
        o_auto_vector_input_n = 1'b1;
        o_breq_n = 1'b1;
        forever
        begin
            @(posedge i_ref_clk);
            if (i_addr_strobe_n === 1'b0)
            begin
                repeat (i_dly) @(posedge i_ref_clk);
                m = i_mode;
                o_ack_n <= (m <= 4'h1 || m == 4'h3) ? 2'b00 : 2'b11;
                o_stop_n <= !(m == 4'h1 || m == 4'h4 || m == 4'h6);
                o_fault_n <= !(m == 4'h2 || m == 4'h4 || m >= 4'h6 && m <= 4'h7);
                o_breq_n <= !(m == 4'h6 || m == 4'h7);
                o_auto_vector_input_n <= (m != 4'h8);
                if (m == 4'h3)
                begin
                    @(posedge i_ref_clk);
                    o_fault_n <= 1'b0;
                end
                while (i_addr_strobe_n !== 1'b1)
                    @(posedge i_ref_clk);
                // fault released before the next cycle reaches its third state
                o_ack_n <= 2'b11;
                o_fault_n <= 1'b1;
                o_auto_vector_input_n <= 1'b1;
                repeat (6) @(posedge i_ref_clk);
                o_stop_n <= 1'b1;
                o_breq_n <= 1'b1;
            end
        end
    end
endmodule // bce_resp

`default_nettype wire

//--- sim/tb_bus_cycle_exception_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_bus_cycle_exception_control;
    localparam logic [9:0] TBL [15] = '{10'h000, 10'h040, 10'h080, 10'h0C0,
        10'h140, 10'h100, 10'h120, 10'h180, 10'h1A1, 10'h1E0, 10'h1C0,
        10'h186, 10'h090, 10'h0D1, 10'h208};
    logic clk, rstn, req, rd, lck, pf, iack, bw, used, flush, e2i, rmw;
    logic [31:0] addr, o_addr;
    logic [3:0] fc, mode, o_fc;
    logic [1:0] size, dly, ack_n, o_size;
    logic fault_n, stop_n, auto_vector_input_n, breq_n, o_read, strb_n, doe_n, coe_n;
    logic lock_n, busy, done, dval, bus_fault_in, pend, retry, halted, rel, wrst;
    logic [15:0] lf;
    int n_mismatch, n_tests;

    bce_ctrl #(.TMO_CYC(16'h0010), .SYNC_CYC(4'h2)) uut (.i_ref_clk(clk),
        .i_resetn(rstn), .i_req(req), .i_req_addr(addr), .i_req_fc(fc),
        .i_req_size(size), .i_req_read(rd), .i_req_locked(lck),
        .i_req_iack(iack), .i_req_prefetch(pf), .i_req_byte_word(bw),
        .i_rmw_seq(rmw), .i_prefetch_used(used), .i_prefetch_flush(flush),
        .i_ext_to_int(e2i), .i_data_size_ack_n(ack_n),
        .i_bus_fault_in_n(fault_n), .i_stop_n(stop_n),
        .i_auto_vector_input_n(auto_vector_input_n), .i_mastership_request_n(breq_n),
        .o_addr(o_addr), .o_fc(o_fc), .o_size(o_size), .o_read(o_read),
        .o_addr_strobe_n(strb_n), .o_data_oe_n(doe_n), .o_ctrl_oe_n(coe_n),
        .o_locked_rmw_n(lock_n), .o_busy(busy), .o_done(done),
        .o_data_valid(dval), .o_bus_error(bus_fault_in), .o_err_pending(pend),
        .o_retry(retry), .o_halted(halted), .o_bus_released(rel),
        .o_word_restart(wrst));

    bce_resp resp (.i_ref_clk(clk), .i_addr_strobe_n(strb_n), .i_mode(mode),
        .i_dly(dly), .o_ack_n(ack_n), .o_fault_n(fault_n), .o_stop_n(stop_n),
        .o_auto_vector_input_n(auto_vector_input_n), .o_breq_n(breq_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input string what, input logic [39:0] exp,
        input logic [39:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic close_out;
        $display("counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // one bus cycle against the reference model
    // ------------------------------------------------------------
    task automatic run(input logic [9:0] t);
        int m = t[9:6];
        int l = t[5];
        int f = (m == 2 || m == 3 || m == 5 || m == 7 && l == 0);
        int e_rel = (m == 6 && l == 0 || m == 7 && l == 1);
        int e_rt = (m == 4 || m == 6 && l == 1);
        int e_rst = e_rel && t[2] && t[1];
        int e_str = 1 + ((e_rt || e_rel) && !e_rst);
        int c_str = 0, c_err = 0, c_rt = 0, c_rel = 0, c_rst = 0, c_val = 0;
        int c_done = 0, c_halt = 0, tail = 0;
        logic prev = 1'b1;
        logic [31:0] ea;
        logic [31:0] q[$];
        lf = lfsr(lf);
        ea[31:16] = lf;
        lf = lfsr(lf);
        ea[15:0] = lf;
        repeat (e_str) q.push_back(ea);
        @(posedge clk);
        {lck, pf, iack, bw, e2i} <= t[5:1];
        rmw <= t[5] & t[0];
        mode <= t[9:6];
        addr <= ea;
        fc <= lf[3:0];
        size <= lf[5:4];
        dly <= lf[7:6];
        rd <= t[3] | lf[8];
        req <= 1'b1;
        for (int k = 0; k < 400; k++)
        begin
            @(posedge clk);
            if (busy === 1'b1)
                req <= 1'b0;
            if (prev === 1'b1 && strb_n === 1'b0)
            begin
                c_str++;
                if (q.size() > 0)
                    check("address", q.pop_front(), o_addr);
                check("access", {fc, size, rd}, {o_fc, o_size, o_read});
            end
            prev = strb_n;
            if (rel === 1'b1)
                check("released ctrl", 1, coe_n);
            if (halted === 1'b1)
                check("halt hold", {ea, 2'b11}, {o_addr, strb_n, doe_n});
            if (l == 1 && c_str > 0 && c_done == 0 && rel !== 1'b1
                && done !== 1'b1)
                check("lock", 0, lock_n);
            if (retry === 1'b1 || rel === 1'b1)
                mode <= 4'h0;
            c_err += (bus_fault_in === 1'b1);
            c_rt += (retry === 1'b1);
            c_rel += (rel === 1'b1);
            c_rst += (wrst === 1'b1);
            c_val += (dval === 1'b1);
            c_done += (done === 1'b1);
            c_halt += (halted === 1'b1);
            if (c_done > 0)
                tail++;
            if (tail > 12 && busy === 1'b0 && halted === 1'b0)
                break;
        end
        check("strobes", e_str, c_str);
        check("bus errors", f && !t[4], c_err);
        if (e_rel == 0)
            check("retries", e_rt, c_rt);
        check("released", e_rel, c_rel > 0);
        check("word restart", e_rst, c_rst);
        check("done", 1, c_done);
        if (t[3] == 0)
            check("valid", rd && !f && !e_rst, c_val);
        check("halted", m == 1, c_halt > 0);
        check("pending", f && t[4], pend);
        if (t[4] == 1)
        begin
            used <= !t[0];
            flush <= t[0];
            @(posedge clk);
            used <= 1'b0;
            flush <= 1'b0;
            c_err = 0;
            repeat (6)
            begin
                @(posedge clk);
                c_err += (bus_fault_in === 1'b1);
            end
            check("deferred error", !t[0], c_err);
            check("pending cleared", 0, pend);
        end
        $display("test with mode %0d finished", m);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever
            #20 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        close_out();
    end

    initial
    begin
        {rstn, req, rd, lck, pf, iack, bw, used, flush, e2i, rmw} = '0;
        addr = 32'h0000_0000;
        fc = 4'h0;
        size = 2'h0;
        dly = 2'h0;
        mode = 4'h0;
        lf = 16'h0043;
        n_mismatch = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        check("reset outputs", {32'h0000_0000, 5'h1B},
            {o_addr, strb_n, doe_n, coe_n, lock_n, o_read});
        for (int i = 0; i < 15; i++)
            run(TBL[i]);
        close_out();
    end
endmodule // tb_bus_cycle_exception_control

`default_nettype wire
